// File: core/tc_readout.sv
// thermocouple readout core: io bus byte port, axi-lite registers
`timescale 1ns/1ps
// What this block does
// - one reading is four consecutive byte addresses
// - one channel delivered per cpu sweep
// - channels presented in sequence across sweeps
// - advance channel after its word is read
// - read indexing independent of sampling rate
// - jumper picks signed magnitude or twos complement
// - sample each input 66.4 ms window, 60 ms at 50 Hz, 50 ms at 60 Hz
// - average 12-bit samples, offset, convert
// - revisit each channel every 531.2 ms, 480 ms at 50 Hz, 400 ms at 60 Hz
// - jumper selects 50 or 60 Hz rates
// - detect open input, underrange and overrange
// - report celsius or fahrenheit from eight channels
// - reading carries flags and channel number
// - drive bus only on own addresses
// - front-panel indicator shows module health
// - bits 1-3 channel number, others unused
// - status bits valid open sign ok under over
// - bit 16 toggles at each completed reading
// - bits 17-28 data, 29-32 sign extension
module tc_readout #(
   parameter int unsigned ADDR_W    = 10,
   parameter int unsigned WIN_CYC   = tc_pkg::WIN_DEF_CYC,
   parameter int unsigned WIN50_CYC = tc_pkg::WIN_50_CYC,
   parameter int unsigned WIN60_CYC = tc_pkg::WIN_60_CYC
) (
   input  wire logic              core_clk,      // 100 MHz clock
   input  wire logic              reset_n,       // async reset, low
   // axi4-lite slave
   input  wire logic [3:0]        s_axi_awaddr,  // write address
   input  wire logic              s_axi_awvalid, // write addr valid
   output logic                   s_axi_awready, // write addr ready
   input  wire logic [31:0]       s_axi_wdata,   // write data
   input  wire logic [3:0]        s_axi_wstrb,   // byte enables
   input  wire logic              s_axi_wvalid,  // write data valid
   output logic                   s_axi_wready,  // write data ready
   output logic [1:0]             s_axi_bresp,   // write response
   output logic                   s_axi_bvalid,  // response valid
   input  wire logic              s_axi_bready,  // response ready
   input  wire logic [3:0]        s_axi_araddr,  // read address
   input  wire logic              s_axi_arvalid, // read addr valid
   output logic                   s_axi_arready, // read addr ready
   output logic [31:0]            s_axi_rdata,   // read data
   output logic [1:0]             s_axi_rresp,   // read response
   output logic                   s_axi_rvalid,  // read data valid
   input  wire logic              s_axi_rready,  // read data ready
   // cpu i/o bus
   input  wire logic [ADDR_W-1:0] io_addr,       // byte address
   input  wire logic              io_rd,         // read strobe, high
   input  wire logic [ADDR_W-3:0] io_base,       // group switch strap
   output logic [7:0]             io_data,       // data byte out
   output logic                   io_data_oe,    // drive enable
   // jumpers, supplies, converter
   input  wire logic              fmt_twos,      // jumper: 2's compl
   input  wire logic [1:0]        rate_sel,      // jumper: mains rate
   input  wire logic              supply_ok,     // supplies in range
   input  wire logic [11:0]       adc_data,      // converter code
   input  wire logic              adc_open,      // open detector
   output logic [2:0]             adc_ch,        // converter mux
   output logic                   led_ok         // health indicator
);
   initial begin
      if (ADDR_W < 3 || ADDR_W > 16)
         $error("io address width out of range");
   end

   tc_conv_if cv ();

   // ****************************************************
   // pin synchronisers
   // ****************************************************
   logic [ADDR_W-1:0] ad_s1, ad_s2;
   logic [ADDR_W-3:0] bs_s1, bs_s2;
   logic              rd_s1, rd_s2, rd_d;
   logic              tw_s1, tw_s2, ok_s1, ok_s2;
   logic [1:0]        rt_s1, rt_s2;

   // two flops on every i/o bus, jumper and supply input
   always_ff @(posedge core_clk or negedge reset_n)
      if (!reset_n)
      begin
         ad_s1 <= '0;
         ad_s2 <= '0;
         bs_s1 <= '0;
         bs_s2 <= '0;
         rd_s1 <= 1'b0;
         rd_s2 <= 1'b0;
         rd_d  <= 1'b0;
         tw_s1 <= 1'b0;
         tw_s2 <= 1'b0;
         ok_s1 <= 1'b0;
         ok_s2 <= 1'b0;
         rt_s1 <= 2'h0;
         rt_s2 <= 2'h0;
      end
      else
      begin
         ad_s1 <= io_addr;
         ad_s2 <= ad_s1;
         bs_s1 <= io_base;
         bs_s2 <= bs_s1;
         rd_s1 <= io_rd;
         rd_s2 <= rd_s1;
         rd_d  <= rd_s2;
         tw_s1 <= fmt_twos;
         tw_s2 <= tw_s1;
         ok_s1 <= supply_ok;
         ok_s2 <= ok_s1;
         rt_s1 <= rate_sel;
         rt_s2 <= rt_s1;
      end

   tc_sampler #(
      .WIN_CYC   (WIN_CYC),
      .WIN50_CYC (WIN50_CYC),
      .WIN60_CYC (WIN60_CYC)
   ) u_smp (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .rate_sel (rt_s2),
      .adc_data (adc_data),
      .adc_open (adc_open),
      .cv       (cv.src)
   );

   // ****************************************************
   // axi4-lite register slave
   // ****************************************************
   logic [31:0] ctrl;
   logic [11:0] zero;
   logic [3:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        aw_full, w_full, unit_f;
   logic [2:0]  rd_ptr, last_ch;
   logic        beat;

   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] dat, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            r[i*8 +: 8] = dat[i*8 +: 8];
      return r;
   endfunction : merge

   assign unit_f = ctrl[0];

   // write channel: address and data in either order
   always_ff @(posedge core_clk or negedge reset_n)
      if (!reset_n)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= tc_pkg::RESP_OKAY;
         aw_full       <= 1'b0;
         w_full        <= 1'b0;
         aw_addr       <= 4'h0;
         w_data        <= 32'h0;
         w_strb        <= 4'h0;
         ctrl          <= tc_pkg::CTRL_RST;
         zero          <= tc_pkg::ZERO_RST;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_addr       <= s_axi_awaddr;
            aw_full       <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            w_full       <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (aw_full && w_full && !s_axi_bvalid)
         begin
            aw_full      <= 1'b0;
            w_full       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= tc_pkg::RESP_OKAY;
            if (aw_addr == tc_pkg::OFF_CTRL)
               ctrl <= merge(ctrl, w_data, w_strb);
            else if (aw_addr == tc_pkg::OFF_ZERO)
               zero <= 12'(merge(32'(zero), w_data, w_strb));
            else if (aw_addr != tc_pkg::OFF_STAT)
               s_axi_bresp <= tc_pkg::RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end

   // read channel: answer one cycle after the address
   always_ff @(posedge core_clk or negedge reset_n)
      if (!reset_n)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= tc_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= tc_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            tc_pkg::OFF_CTRL: s_axi_rdata <= ctrl;
            tc_pkg::OFF_ZERO: s_axi_rdata <= 32'(zero);
            tc_pkg::OFF_STAT: s_axi_rdata <= 32'({beat, ok_s2,
                                 1'b0, last_ch, 1'b0, rd_ptr});
            default:
            begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= tc_pkg::RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end

   // ****************************************************
   // conversion to temperature word
   // ****************************************************
   logic signed [13:0] rel;
   logic signed [17:0] deg, mag;
   logic               neg, over, under;
   logic [11:0]        tmag, tval;
   logic [31:0]        new_word;

   // offset, optional fahrenheit scale, range and format
   always_comb
   begin
      rel = $signed({2'b00, cv.avg}) - $signed({2'b00, zero});
      deg = unit_f ? (18'(rel) * tc_pkg::F_MUL) / tc_pkg::F_DIV
                     + tc_pkg::F_OFS : 18'(rel);
      neg  = deg[17];
      mag  = neg ? -deg : deg;
      over = (cv.avg == 12'hfff) || (!neg && mag > 18'sh00fff);
      under = (cv.avg == 12'h000) || (neg && mag > 18'sh00fff);
      tmag = (mag > 18'sh00fff) ? 12'hfff : mag[11:0];
      tval = (tw_s2 && neg) ? 12'(~tmag + 12'h001) : tmag;
      new_word = 32'h0;
      new_word[tc_pkg::W_CH +: 3]  = cv.ch;
      new_word[tc_pkg::W_VALID]    = !cv.open_in && !over && !under;
      new_word[tc_pkg::W_OPEN]     = cv.open_in;
      new_word[tc_pkg::W_SIGN]     = neg;
      new_word[tc_pkg::W_OK]       = ok_s2;
      new_word[tc_pkg::W_UNDER]    = under;
      new_word[tc_pkg::W_OVER]     = over;
      new_word[tc_pkg::W_BEAT]     = ~beat;
      new_word[tc_pkg::W_DATA +: 12] = tval;
      new_word[tc_pkg::W_EXT +: 4] = (tw_s2 && neg) ? 4'hf : 4'h0;
   end

   logic [31:0] res [tc_pkg::NUM_CH];

   // per-channel result store, heartbeat, health lamp
   always_ff @(posedge core_clk or negedge reset_n)
      if (!reset_n)
      begin
         for (int i = 0; i < tc_pkg::NUM_CH; i++)
            res[i] <= 32'(i);
         beat    <= 1'b0;
         last_ch <= 3'h0;
         led_ok  <= 1'b0;
         adc_ch  <= 3'h0;
      end
      else
      begin
         adc_ch <= cv.adc_ch;
         if (cv.done)
         begin
            res[cv.ch] <= new_word;
            beat       <= ~beat;
            last_ch    <= cv.ch;
         end
         led_ok <= ok_s2 && (beat || last_ch != 3'h0 || cv.done);
      end

   // ****************************************************
   // cpu i/o bus byte port
   // ****************************************************
   logic        hit, rise;
   logic [1:0]  bsel;
   logic [31:0] held;

   assign hit  = (ad_s2[ADDR_W-1:2] == bs_s2);
   assign rise = rd_s2 && !rd_d;
   assign bsel = ad_s2[1:0];

   // byte fetch, word hold, channel advance
   always_ff @(posedge core_clk or negedge reset_n)
      if (!reset_n)
      begin
         io_data    <= 8'h00;
         io_data_oe <= 1'b0;
         rd_ptr     <= 3'h0;
         held       <= 32'h0;
      end
      else
      begin
         io_data_oe <= rd_s2 && hit;
         if (rise && hit)
         begin
            if (bsel == 2'h0)
            begin
               held    <= res[rd_ptr];
               io_data <= res[rd_ptr][7:0];
            end
            else
               io_data <= held[bsel*8 +: 8];
            if (bsel == tc_pkg::LAST_BYTE)
               rd_ptr <= rd_ptr + 3'h1;
         end
      end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   chk_ptr_advance: assert property (rise && hit && bsel ==
      tc_pkg::LAST_BYTE |=> rd_ptr == 3'($past(rd_ptr) + 3'h1))
      else $error("pointer did not advance");
   chk_ptr_holds: assert property (!(rise && hit && bsel ==
      tc_pkg::LAST_BYTE) |=> $stable(rd_ptr))
      else $error("pointer moved early");
   chk_oe_decode: assert property (io_data_oe |->
      $past(rd_s2 && ad_s2[ADDR_W-1:2] == bs_s2))
      else $error("bus driven off own address");
   chk_first_chan: assert property (rise && hit && bsel == 2'h0
      |=> io_data[2:0] == $past(rd_ptr))
      else $error("channel field wrong");
   chk_beat_toggle: assert property (cv.done |=> beat != $past(beat)
      && res[$past(cv.ch)][tc_pkg::W_BEAT] == beat)
      else $error("heartbeat not toggled");
   chk_sm_ext: assert property (cv.done && !tw_s2 |=>
      res[$past(cv.ch)][31:28] == 4'h0)
      else $error("extension not zero");
   chk_open_flag: assert property (cv.done && cv.open_in |=>
      res[$past(cv.ch)][tc_pkg::W_OPEN]
      && !res[$past(cv.ch)][tc_pkg::W_VALID])
      else $error("open input not flagged");
   chk_axi_read: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");

   cov_full_word: cover property (rise && hit && bsel == 2'h3);
   cov_reg_write: cover property (s_axi_bvalid && s_axi_bready);
   cov_neg_twos: cover property (cv.done && neg && tw_s2);
endmodule : tc_readout

// File: core/tc_pkg.sv
// shared constants for the thermocouple channel readout
package tc_pkg;
   localparam int unsigned CLK_MHZ      = 100;
   localparam int unsigned WIN_DEF_US   = 66400;
   localparam int unsigned WIN_50_US    = 60000;
   localparam int unsigned WIN_60_US    = 50000;
   localparam int unsigned WIN_DEF_CYC  = WIN_DEF_US * CLK_MHZ;
   localparam int unsigned WIN_50_CYC   = WIN_50_US * CLK_MHZ;
   localparam int unsigned WIN_60_CYC   = WIN_60_US * CLK_MHZ;
   localparam int unsigned SMP_LOG2     = 4;
   localparam int unsigned NUM_CH       = 8;
   // axi register byte offsets
   localparam logic [3:0]  OFF_CTRL     = 4'h0;
   localparam logic [3:0]  OFF_ZERO     = 4'h4;
   localparam logic [3:0]  OFF_STAT     = 4'h8;
   localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
   localparam logic [11:0] ZERO_RST     = 12'h000;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;
   // rate jumper codes
   localparam logic [1:0]  RATE_50      = 2'h1;
   localparam logic [1:0]  RATE_60      = 2'h2;
   // reading word bit positions
   localparam int unsigned W_CH         = 0;
   localparam int unsigned W_VALID      = 8;
   localparam int unsigned W_OPEN       = 10;
   localparam int unsigned W_SIGN       = 11;
   localparam int unsigned W_OK         = 12;
   localparam int unsigned W_UNDER      = 13;
   localparam int unsigned W_OVER       = 14;
   localparam int unsigned W_BEAT       = 15;
   localparam int unsigned W_DATA       = 16;
   localparam int unsigned W_EXT        = 28;
   localparam logic [1:0]  LAST_BYTE    = 2'h3;
   // fahrenheit scaling
   localparam logic signed [17:0] F_MUL = 18'sh00009;
   localparam logic signed [17:0] F_DIV = 18'sh00005;
   localparam logic signed [17:0] F_OFS = 18'sh00020;
endpackage : tc_pkg

// File: core/tc_conv_if.sv
// conversion results passed from the sampler to the readout core
`timescale 1ns/1ps
interface tc_conv_if;
   logic        done;      // one-cycle pulse, window finished
   logic [2:0]  ch;        // channel of the finished window
   logic [11:0] avg;       // averaged 12-bit code
   logic        open_in;   // open input seen during the window
   logic [2:0]  adc_ch;    // channel now routed to the converter
   modport src (output done, ch, avg, open_in, adc_ch);
   modport dst (input done, ch, avg, open_in, adc_ch);
endinterface : tc_conv_if

// File: core/tc_sampler.sv
// per-channel sampling window, averaging and channel scan
`timescale 1ns/1ps
module tc_sampler #(
   parameter int unsigned WIN_CYC   = tc_pkg::WIN_DEF_CYC,
   parameter int unsigned WIN50_CYC = tc_pkg::WIN_50_CYC,
   parameter int unsigned WIN60_CYC = tc_pkg::WIN_60_CYC
) (
   input  wire logic        core_clk,  // system clock
   input  wire logic        reset_n,   // async reset, low
   input  wire logic [1:0]  rate_sel,  // synced rate jumper
   input  wire logic [11:0] adc_data,  // converter code pins
   input  wire logic        adc_open,  // open detector pin
   tc_conv_if.src           cv         // results out
);
   localparam int unsigned NSMP = 1 << tc_pkg::SMP_LOG2;
   localparam logic [31:0] TK_D = 32'(WIN_CYC / NSMP);
   localparam logic [31:0] TK_5 = 32'(WIN50_CYC / NSMP);
   localparam logic [31:0] TK_6 = 32'(WIN60_CYC / NSMP);

   initial begin
      if (TK_D < 2 || TK_5 < 2 || TK_6 < 2)
         $error("sampling windows too short");
   end

   logic [11:0] adc_s1, adc_s2;
   logic        opn_s1, opn_s2;
   logic [31:0] tick_len, tick_cnt;
   logic [3:0]  smp_cnt;
   logic [15:0] acc;
   logic        opn_acc;
   logic [2:0]  cur;
   logic        tick_end;

   // pin synchronisers
   always_ff @(posedge core_clk or negedge reset_n)
      if (!reset_n)
      begin
         adc_s1 <= 12'h000;
         adc_s2 <= 12'h000;
         opn_s1 <= 1'b0;
         opn_s2 <= 1'b0;
      end
      else
      begin
         adc_s1 <= adc_data;
         adc_s2 <= adc_s1;
         opn_s1 <= adc_open;
         opn_s2 <= opn_s1;
      end

   // tick length from the mains rate jumper
   always_comb
      unique case (rate_sel)
         tc_pkg::RATE_50: tick_len = TK_5;
         tc_pkg::RATE_60: tick_len = TK_6;
         default:         tick_len = TK_D;
      endcase

   assign tick_end = (tick_cnt >= tick_len - 32'h1);

   // window timing, averaging, channel scan
   always_ff @(posedge core_clk or negedge reset_n)
      if (!reset_n)
      begin
         tick_cnt   <= 32'h0;
         smp_cnt    <= 4'h0;
         acc        <= 16'h0000;
         opn_acc    <= 1'b0;
         cur        <= 3'h0;
         cv.done    <= 1'b0;
         cv.ch      <= 3'h0;
         cv.avg     <= 12'h000;
         cv.open_in <= 1'b0;
      end
      else
      begin
         cv.done  <= 1'b0;
         tick_cnt <= tick_end ? 32'h0 : tick_cnt + 32'h1;
         if (tick_end)
         begin
            smp_cnt <= smp_cnt + 4'h1;
            if (smp_cnt == 4'hf)
            begin
               // 16 samples summed; shift gives the mean
               cv.avg     <= 12'((acc + 16'(adc_s2)) >> tc_pkg::SMP_LOG2);
               cv.open_in <= opn_acc | opn_s2;
               cv.ch      <= cur;
               cv.done    <= 1'b1;
               cur        <= cur + 3'h1;
               acc        <= 16'h0000;
               opn_acc    <= 1'b0;
            end
            else
            begin
               acc     <= acc + 16'(adc_s2);
               opn_acc <= opn_acc | opn_s2;
            end
         end
      end

   assign cv.adc_ch = cur;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   chk_scan_step: assert property (cv.done |-> cv.ch == 3'($past(cur))
      && cur == 3'($past(cur) + 3'h1)) else $error("scan step wrong");
   chk_mux_pace: assert property ($changed(cur) |-> cv.done)
      else $error("mux moved off window end");
   chk_done_gap: assert property (cv.done |=> !cv.done [*8])
      else $error("window too short");
   cov_open_win: cover property (cv.done && cv.open_in);
endmodule : tc_sampler

// File: dv/tc_cpu_sweep.sv
// cpu i/o sweep model: reads the four bytes of one channel word
`timescale 1ns/1ps
module tc_cpu_sweep (
   input  wire logic       core_clk,   // system clock
   input  wire logic [7:0] io_data,    // byte from module
   input  wire logic       io_data_oe, // module drives bus
   output logic [9:0]      io_addr,    // byte address
   output logic            io_rd       // read strobe, high
);
   // ****************************
   // sweep of one word
   // ****************************
   // idle bus at time zero
   initial
   begin
      io_addr = 10'h000;
      io_rd   = 1'b0;
   end
   // bytes 0..3 at rising addresses, strobe low between
   task sweep(input logic [7:0] grp, output logic [31:0] w,
              output logic seen);
      int b;
      int n;
      seen = 1'b0;
      for (b = 0; b < 4; b++)
      begin
         @(posedge core_clk);
         io_addr <= {grp, b[1:0]};
         @(posedge core_clk);
         io_rd <= 1'b1;
         for (n = 0; n < 12 && io_data_oe !== 1'b1; n++)
            @(posedge core_clk);
         if (io_data_oe === 1'b1)
            seen = 1'b1;
         w[8*b +: 8] = io_data;
         io_rd <= 1'b0;
         for (n = 0; n < 12 && io_data_oe !== 1'b0; n++)
            @(posedge core_clk);
         repeat (3) @(posedge core_clk);
      end
   endtask : sweep
endmodule : tc_cpu_sweep

// File: dv/testbench.sv
// self-checking testbench for the thermocouple readout core
`timescale 1ns/1ps
module testbench;
   logic        core_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [3:0]  s_axi_awaddr = 4'h0;
   logic        s_axi_awvalid = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  rate_sel = 2'h0;
   logic [1:0]  wr_resp;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0;
   logic [3:0]  s_axi_araddr = 4'h0;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic        fmt_twos = 1'b0;
   logic        supply_ok = 1'b1;
   logic [11:0] adc_data = 12'h123;
   logic        adc_open = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, io_rd, io_data_oe, led_ok;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [9:0]  io_addr;
   logic [7:0]  io_data;
   logic [2:0]  adc_ch;
   int          errors = 0;
   int          tests_run = 0;
   int          cyc = 0;
   // ****************************
   // design, cpu model, clock
   // ****************************
   tc_readout #(.WIN_CYC(320), .WIN50_CYC(480), .WIN60_CYC(320))
   u_tc_readout (
      .core_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .io_addr, .io_rd, .io_base(8'h05),
      .io_data, .io_data_oe, .fmt_twos, .rate_sel, .supply_ok,
      .adc_data, .adc_open, .adc_ch, .led_ok);
   tc_cpu_sweep u_tc_cpu_sweep (.core_clk, .io_data, .io_data_oe,
      .io_addr, .io_rd);
   // 100 MHz clock
   always #5 core_clk = ~core_clk;
   // hang guard
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 80000)
      begin
         errors++;
         results;
      end
   end
   // compare and count
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
      tests_run++;
      if (seen !== ex)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, ex, seen);
      end
   endtask : chk
   // axi4-lite write, address and data offered together
   task axi_wr(input logic [3:0] a, input logic [31:0] d);
      logic busy;
      busy = 1'b1;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (busy)
      begin
         @(posedge core_clk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid)
         begin
            busy = 1'b0;
            wr_resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
         end
      end
   endtask : axi_wr
   // axi4-lite read
   task axi_rd(input logic [3:0] a, output logic [31:0] d,
               output logic [1:0] r);
      logic busy;
      busy = 1'b1;
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (busy)
      begin
         @(posedge core_clk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid)
         begin
            busy = 1'b0;
            s_axi_rready <= 1'b0;
            d = s_axi_rdata;
            r = s_axi_rresp;
         end
      end
   endtask : axi_rd
   // channel order, wrap and address decode
   task t_scan;
      logic [31:0] w;
      logic        s;
      int          i;
      chk("oe_idle", io_data_oe, 1'b0);
      chk("mux_start", adc_ch, 3'h0);
      for (i = 0; i < 8; i++)
      begin
         u_tc_cpu_sweep.sweep(8'h05, w, s); // burst of eight at most
         chk("ch", w[2:0], i[2:0]);
      end
      repeat (200) @(posedge core_clk); // rest after a burst
      u_tc_cpu_sweep.sweep(8'h06, w, s);
      chk("miss_oe", s, 1'b0);
      u_tc_cpu_sweep.sweep(8'h05, w, s);
      chk("wrap", w[2:0], 3'h0);
   endtask : t_scan
   // one conversion setting, then the reading word
   task t_conv(input logic [11:0] adc, input logic op, input logic [11:0] z,
               input logic tw, input logic fh, input logic [7:0] fl,
               input logic [15:0] hi, input logic use_hi);
      logic [31:0] w;
      logic [1:0]  rs;
      logic        s;
      @(posedge core_clk);
      adc_data <= adc;
      adc_open <= op;
      fmt_twos <= tw;
      axi_wr(4'h0, {31'h0, fh});
      axi_wr(4'h4, {20'h0, z});
      chk("wr_ok", wr_resp, 2'h0);
      repeat (5200) @(posedge core_clk); // two full scans at 320-cycle windows, one at 480
      u_tc_cpu_sweep.sweep(8'h05, w, s);
      chk("flags", w[15:8] & 8'h7d, fl);
      if (use_hi)
         chk("data", w[31:16], hi);
      axi_rd(4'h4, w, rs);
      chk("zero", w, {20'h0, z});
   endtask : t_conv
   // health lamp, status and unmapped register
   task t_regs;
      logic [31:0] d;
      logic [1:0]  r;
      chk("led_on", led_ok, 1'b1);
      axi_rd(4'h8, d, r);
      chk("stat_ok", d[8], 1'b1);
      axi_rd(4'hc, d, r);
      chk("unmap_resp", r, 2'h2);
      chk("unmap_data", d, 32'h0);
      axi_wr(4'hc, 32'h0000_0055);
      chk("unmap_wr", wr_resp, 2'h2);
      @(posedge core_clk);
      s_axi_wstrb <= 4'h2;
      axi_wr(4'h4, 32'h0000_0a55);
      axi_rd(4'h4, d, r);
      chk("zero_lane", d, 32'h0000_0a00);
      s_axi_wstrb <= 4'hf;
      supply_ok <= 1'b0;
      repeat (10) @(posedge core_clk);
      chk("led_off", led_ok, 1'b0);
   endtask : t_regs
   // verdict
   task results;
      if (errors == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : results
   // main sequence
   initial
   begin
      repeat (5) @(posedge core_clk);
      reset_n <= 1'b1;
      t_scan;
      t_conv(12'h123, 1'b0, 12'h000, 1'b0, 1'b0, 8'h11, 16'h0123, 1'b1);
      rate_sel <= 2'h1;
      t_conv(12'h123, 1'b0, 12'h200, 1'b1, 1'b0, 8'h19, 16'hff23, 1'b1);
      rate_sel <= 2'h2;
      t_conv(12'h123, 1'b0, 12'h200, 1'b0, 1'b0, 8'h19, 16'h00dd, 1'b1);
      rate_sel <= 2'h0;
      t_conv(12'h123, 1'b0, 12'h000, 1'b0, 1'b1, 8'h11, 16'h022b, 1'b1);
      t_conv(12'h123, 1'b1, 12'h000, 1'b0, 1'b0, 8'h14, 16'h0000, 1'b0);
      t_conv(12'h000, 1'b0, 12'h000, 1'b0, 1'b0, 8'h30, 16'h0000, 1'b0);
      t_conv(12'hfff, 1'b0, 12'h000, 1'b0, 1'b0, 8'h50, 16'h0000, 1'b0);
      t_regs;
      results;
   end
endmodule : testbench
